//--- hts_pkg.sv
// Purpose: shared constants and types of the humidity and temperature sensor control
// Assumes: system clock of 20 MHz (50 ns period)
// Notes: times are kept in ns, cycle counts derive from them
package hts_pkg;

    localparam int unsigned CLK_NS = 50;

    // start-up interval, longest time, so round down
    localparam int unsigned T_START_NS = 15000000;
    localparam int unsigned START_CYC = T_START_NS / CLK_NS;

    // conversion times, rounded up to whole cycles
    localparam int unsigned T_HUM8_NS = 2500000;
    localparam int unsigned T_HUM11_NS = 3850000;
    localparam int unsigned T_HUM14_NS = 6500000;
    localparam int unsigned T_TMP11_NS = 3650000;
    localparam int unsigned T_TMP14_NS = 6350000;
    localparam int unsigned HUM8_CYC = (T_HUM8_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned HUM11_CYC = (T_HUM11_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned HUM14_CYC = (T_HUM14_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TMP11_CYC = (T_TMP11_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TMP14_CYC = (T_TMP14_NS + CLK_NS - 1) / CLK_NS;

    // input spike suppression: a spike of this width or less is ignored
    localparam int unsigned T_SPIKE_NS = 50;
    localparam int unsigned SPIKE_CYC = T_SPIKE_NS / CLK_NS + 1;

    // width of the conversion and start-up counters
    localparam int unsigned CNT_W = 20;

    // configuration word layout
    localparam int unsigned CFG_W = 16;
    localparam logic [7:0] CFG_ADDR = 8'h02;
    localparam int unsigned CFG_HEATER_ENABLE_BIT = 13;
    localparam int unsigned CFG_BOTH_BIT = 12;
    localparam int unsigned CFG_SLOW_BIT = 11;
    localparam int unsigned CFG_TRES_BIT = 10;
    localparam int unsigned CFG_HRES_LSB = 8;
    localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
    localparam logic [CFG_W-1:0] CFG_WR_MASK = 16'h3700;

    // resolution encodings
    localparam logic TRES_14 = 1'b0;
    localparam logic [1:0] HRES_14 = 2'h0;
    localparam logic [1:0] HRES_11 = 2'h1;
    localparam logic [1:0] HRES_8 = 2'h2;

    // operating modes, gray coded along sleep -> temp -> hum
    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00,
        ST_TEMP = 2'b01,
        ST_HUM = 2'b11
    } hts_state_e;

endpackage : hts_pkg

//--- hts_spike_filter.sv
// Purpose: synchronise and deglitch the serial clock and data pins
// Assumes: pins are asynchronous to sys_clk
// Notes: an output bit follows its pin only after SPIKE_CYC equal samples
module hts_spike_filter
    import hts_pkg::*;
#(
    parameter int unsigned W = 2
)(
    input wire logic sys_clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [W-1:0] pin_in, // raw pin levels
    output logic [W-1:0] filt_out // deglitched levels
);

    localparam int unsigned FC_W = 4;
    localparam logic [FC_W-1:0] FC_LAST = FC_W'(SPIKE_CYC - 1);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] out;
        logic [W-1:0][FC_W-1:0] cnt;
    } hts_filt_s;

    hts_filt_s q, d;

    ////////////////////////////////////////////////////////////////////////////
    // per bit: count differing samples, flip only on a full run
    always_comb
    begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        for (int i = 0; i < W; i++)
        begin
            if (q.s2[i] != q.out[i])
            begin
                if (q.cnt[i] == FC_LAST)
                begin
                    d.out[i] = q.s2[i];
                    d.cnt[i] = '0;
                end
                else
                begin
                    d.cnt[i] = q.cnt[i] + FC_W'(1);
                end
            end
            else
            begin
                d.cnt[i] = '0; // a short spike restarts the run
            end
        end
    end

    // idle bus lines are high, so reset to high
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '{s1: '1, s2: '1, out: '1, cnt: '0};
        else
            q <= d;
    end

    assign filt_out = q.out;

    ////////////////////////////////////////////////////////////////////////////
    // per bit: a change is backed by two samples in a row at the new level,
    // so the other pin may move at any time without tripping this
    a_spike_reject: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ((filt_out ^ $past(filt_out)) &
         ((filt_out ^ $past(q.s2, 1)) | (filt_out ^ $past(q.s2, 2)))) == '0)
        else $error("filter output changed on a single sample");

endmodule : hts_spike_filter

//--- hts_ctrl.sv
// Purpose: mode, timing, supply flag and heater control of the sensor
// Assumes: link-side requests come from logic on link_clk; pins are async
// Notes: config and trigger cross from link_clk by toggles with held data
module hts_ctrl
    import hts_pkg::*;
#(
    parameter int unsigned START_CYC_P = START_CYC, // start-up interval
    parameter int unsigned TMP14_CYC_P = TMP14_CYC, // temperature, 14 bit
    parameter int unsigned TMP11_CYC_P = TMP11_CYC, // temperature, 11 bit
    parameter int unsigned HUM14_CYC_P = HUM14_CYC, // humidity, 14 bit
    parameter int unsigned HUM11_CYC_P = HUM11_CYC, // humidity, 11 bit
    parameter int unsigned HUM8_CYC_P = HUM8_CYC // humidity, 8 bit
)(
    input wire logic sys_clk, // system clock, 20 MHz
    input wire logic rst_b, // async power-on reset, active low
    input wire logic link_clk, // serial link clock
    input wire logic link_cfg_we, // config write request, one link cycle
    input wire logic [CFG_W-1:0] link_cfg_wdata, // config write data
    input wire logic link_trig, // measurement trigger, one link cycle
    input wire logic link_trig_hum, // single mode: 1 humidity, 0 temperature
    output logic link_dev_ready, // start-up over, in link domain
    input wire logic scl_pin, // raw serial clock pin
    input wire logic sda_pin, // raw serial data pin
    output logic scl_filt, // deglitched serial clock
    output logic sda_filt, // deglitched serial data
    input wire logic supply_below_thr, // async comparator, high below 2.8 V
    output logic [CFG_W-1:0] cfg_rdata, // config word readback
    output logic supply_low_flag, // held supply-low indication
    output logic heater_enable, // heater enable bit
    output logic heater_on, // heater drive
    output logic meas_active, // measurement mode
    output logic dev_ready, // start-up over
    output logic result_ready_n // result ready, active low
);

    ////////////////////////////////////////////////////////////////////////////
    // link domain state: requests are held and flagged by toggles
    typedef struct packed {
        logic cfg_tgl;
        logic [CFG_W-1:0] cfg_data;
        logic trig_tgl;
        logic trig_hum;
        logic [1:0] rdy_sync;
    } hts_link_s;

    hts_link_s lq, ld;

    // the host keeps requests apart by at least four sys_clk periods
    always_comb
    begin
        ld = lq;
        ld.rdy_sync = {lq.rdy_sync[0], dev_ready};
        if (link_cfg_we)
        begin
            ld.cfg_tgl = ~lq.cfg_tgl;
            ld.cfg_data = link_cfg_wdata;
        end
        if (link_trig)
        begin
            ld.trig_tgl = ~lq.trig_tgl;
            ld.trig_hum = link_trig_hum;
        end
    end

    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
            lq <= '{cfg_tgl: 1'b0, cfg_data: CFG_RST, trig_tgl: 1'b0,
                    trig_hum: 1'b0, rdy_sync: 2'b00};
        else
            lq <= ld;
    end

    assign link_dev_ready = lq.rdy_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // pin deglitching
    hts_spike_filter #(
        .W(2)
    ) u_filt (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in({scl_pin, sda_pin}),
        .filt_out({scl_filt, sda_filt})
    );

    ////////////////////////////////////////////////////////////////////////////
    // system domain state
    typedef struct packed {
        hts_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] boot_cnt;
        logic booted;
        logic [CFG_W-1:0] cfg;
        logic both;
        logic supply_low;
        logic rdy_n;
        logic heater_enable_on;
        logic [1:0] sup_sync;
        logic [2:0] cfg_sync;
        logic [2:0] trig_sync;
    } hts_sys_s;

    hts_sys_s q, d;

    logic cfg_ev;
    logic trig_ev;
    logic [CNT_W-1:0] tmp_load;
    logic [CNT_W-1:0] hum_load;

    // edge of the second-stage toggles against the third
    assign cfg_ev = q.cfg_sync[2] ^ q.cfg_sync[1];
    assign trig_ev = q.trig_sync[2] ^ q.trig_sync[1];

    // terminal counts from the current resolution selects
    always_comb
    begin
        if (q.cfg[CFG_TRES_BIT] == TRES_14)
            tmp_load = CNT_W'(TMP14_CYC_P - 1);
        else
            tmp_load = CNT_W'(TMP11_CYC_P - 1);
        unique case (q.cfg[CFG_HRES_LSB +: 2])
            HRES_11: hum_load = CNT_W'(HUM11_CYC_P - 1);
            HRES_8: hum_load = CNT_W'(HUM8_CYC_P - 1);
            default: hum_load = CNT_W'(HUM14_CYC_P - 1); // reserved 11 runs as 14 bit
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up, config, trigger and conversion sequencing
    always_comb
    begin
        d = q;
        d.sup_sync = {q.sup_sync[0], supply_below_thr};
        d.cfg_sync = {q.cfg_sync[1:0], lq.cfg_tgl};
        d.trig_sync = {q.trig_sync[1:0], lq.trig_tgl};
        if (!q.booted)
        begin
            // requests during start-up are dropped, not queued
            if (q.boot_cnt == CNT_W'(START_CYC_P - 1))
            begin
                d.booted = 1'b1;
                d.supply_low = q.sup_sync[1]; // first refresh after reset
            end
            else
            begin
                d.boot_cnt = q.boot_cnt + CNT_W'(1);
            end
        end
        else
        begin
            if (cfg_ev)
            begin
                // only heater, mode and resolution bits are writable
                d.cfg = (q.cfg & ~CFG_WR_MASK) | (lq.cfg_data & CFG_WR_MASK);
            end
            if (trig_ev)
            begin
                // a trigger during a conversion aborts it and restarts
                d.supply_low = q.sup_sync[1];
                d.rdy_n = 1'b1;
                d.both = q.cfg[CFG_BOTH_BIT];
                if (q.cfg[CFG_BOTH_BIT] || !lq.trig_hum)
                begin
                    d.st = ST_TEMP;
                    d.cnt = tmp_load;
                end
                else
                begin
                    d.st = ST_HUM;
                    d.cnt = hum_load;
                end
            end
            else if (q.st != ST_SLEEP)
            begin
                if (q.cnt != '0)
                begin
                    d.cnt = q.cnt - CNT_W'(1);
                end
                else if (q.st == ST_TEMP && q.both)
                begin
                    d.st = ST_HUM; // temperature first, then humidity
                    d.cnt = hum_load;
                end
                else
                begin
                    d.st = ST_SLEEP;
                    d.rdy_n = 1'b0; // stays low until the next trigger
                end
            end
        end
        d.heater_enable_on = d.cfg[CFG_HEATER_ENABLE_BIT] && (d.st != ST_SLEEP);
    end

    // reset: sleep, heater off, flag cleared until start-up ends
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '{st: ST_SLEEP, cnt: '0, boot_cnt: '0, booted: 1'b0, cfg: CFG_RST,
                   both: 1'b0, supply_low: 1'b0, rdy_n: 1'b1, heater_enable_on: 1'b0,
                   sup_sync: 2'b00, cfg_sync: 3'b000, trig_sync: 3'b000};
        else
            q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    always_comb
    begin
        cfg_rdata = q.cfg;
        cfg_rdata[CFG_SLOW_BIT] = q.supply_low;
    end

    assign supply_low_flag = q.supply_low;
    assign heater_enable = q.cfg[CFG_HEATER_ENABLE_BIT];
    assign heater_on = q.heater_enable_on;
    assign meas_active = (q.st != ST_SLEEP);
    assign dev_ready = q.booted;
    assign result_ready_n = q.rdy_n;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_heater_enable_sleep_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (q.st == ST_SLEEP) |-> !heater_on)
        else $error("heater driven while asleep");

    a_heater_enable_meas_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (q.st != ST_SLEEP && heater_enable) |-> heater_on)
        else $error("enabled heater off during measurement");

    a_heater_enable_needs_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
        heater_on |-> heater_enable)
        else $error("heater on without enable");

    a_boot_no_meas: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !dev_ready |-> (q.st == ST_SLEEP && result_ready_n))
        else $error("measurement during start-up");

    a_ready_falls: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $fell(result_ready_n) |-> ($past(q.st) != ST_SLEEP && q.st == ST_SLEEP))
        else $error("result ready without a finished conversion");

    a_trig_rdy_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (trig_ev && q.booted) |=> (result_ready_n && meas_active))
        else $error("trigger did not start a measurement");

    a_flag_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (q.booted && !trig_ev) |=> $stable(supply_low_flag))
        else $error("supply flag changed without a trigger");

    a_flag_refresh: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (q.booted && trig_ev) |=> (supply_low_flag == $past(q.sup_sync[1])))
        else $error("supply flag not refreshed on trigger");

    a_flag_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cfg_rdata[CFG_SLOW_BIT] == supply_low_flag)
        else $error("supply flag missing from config readback");

    a_tmp_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (q.st == ST_TEMP && $past(q.st) == ST_SLEEP) |->
        (q.cnt == ($past(q.cfg[CFG_TRES_BIT]) ? CNT_W'(TMP11_CYC_P - 1)
                                               : CNT_W'(TMP14_CYC_P - 1))))
        else $error("wrong temperature conversion length");

    a_hum_load8: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (q.st == ST_HUM && $past(q.st) != ST_HUM && $past(q.cfg[CFG_HRES_LSB +: 2]) == HRES_8) |->
        (q.cnt == CNT_W'(HUM8_CYC_P - 1)))
        else $error("wrong 8 bit humidity conversion length");

    a_cnt_steps: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (q.st != ST_SLEEP && q.cnt != '0 && !trig_ev) |=>
        (q.cnt == $past(q.cnt) - CNT_W'(1) && q.st == $past(q.st)))
        else $error("conversion counter did not step");

    a_both_seq: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (q.st == ST_TEMP && q.cnt == '0 && !trig_ev) |=>
        (q.both ? (q.st == ST_HUM) : (q.st == ST_SLEEP && !result_ready_n)))
        else $error("wrong step after temperature conversion");

    c_both_hum: cover property (@(posedge sys_clk) disable iff (!rst_b)
        q.both ##1 (q.st == ST_HUM && $past(q.st) == ST_TEMP));

    c_ready_low: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $fell(result_ready_n));

    c_heater_on: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(heater_on));

    c_abort: cover property (@(posedge sys_clk) disable iff (!rst_b)
        (trig_ev && q.st != ST_SLEEP));

endmodule : hts_ctrl

//--- hts_link_master.sv
// Purpose: behavioural two-wire master that issues config writes and triggers
// Assumes: link_clk runs while requests are made
// Notes: a released data word shows its inverse, never a stale copy
module hts_link_master
    import hts_pkg::*;
(
    input wire logic link_clk, // serial link clock
    input wire logic link_dev_ready, // start-up over, link domain
    output logic link_cfg_we, // config write request
    output logic [CFG_W-1:0] link_cfg_wdata, // config write data
    output logic link_trig, // measurement trigger
    output logic link_trig_hum // trigger picks humidity
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////////
    // idle levels at time zero
    initial
    begin
        link_cfg_we = 1'b0;
        link_cfg_wdata = 16'h0000;
        link_trig = 1'b0;
        link_trig_hum = 1'b0;
    end

    // hold off all traffic until start-up is over
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge link_clk);
        while (link_dev_ready !== 1'b1 && n < 1000)
        begin
            @(posedge link_clk);
            n++;
        end
        // a device that never comes up ends the run as a failure
        if (n == 1000)
            tb_top.give_up();
        #1;
    endtask : wait_ready

    // one link cycle write, data released right after the taking edge
    task automatic send_cfg(input logic [CFG_W-1:0] data);
        wait_ready();
        link_cfg_we <= 1'b1;
        link_cfg_wdata <= data;
        @(posedge link_clk);
        #1;
        link_cfg_we <= 1'b0;
        link_cfg_wdata <= ~data;
    endtask : send_cfg

    // one link cycle trigger with its quantity select
    task automatic send_trig(input logic hum);
        wait_ready();
        link_trig <= 1'b1;
        link_trig_hum <= hum;
        @(posedge link_clk);
        #1;
        link_trig <= 1'b0;
        link_trig_hum <= ~hum;
    endtask : send_trig

endmodule : hts_link_master

//--- tb_top.sv
// Purpose: self-checking bench of the sensor control block
// Assumes: shortened start-up and conversion counts
// Notes: pin and reset inputs change at the falling edge of sys_clk; link requests follow link_clk
module tb_top
    import hts_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int START_P = 20;
    localparam int T14_N = 40;
    localparam int T11_N = 30;
    localparam int H14_N = 45;
    localparam int H11_N = 32;
    localparam int H8_N = 20;

    logic sys_clk, rst_b, link_clk, link_cfg_we, link_trig, link_trig_hum, link_dev_ready;
    logic scl_pin, sda_pin, scl_filt, sda_filt, supply_below_thr, supply_low_flag;
    logic heater_enable, heater_on, meas_active, dev_ready, result_ready_n, exp_flag;
    logic [CFG_W-1:0] link_cfg_wdata, cfg_rdata;
    int error_cnt, samples_checked;

    ////////////////////////////////////////////////////////////////////////////////
    // clocks: link clock offset so its edges never meet sys_clk edges
    initial
    begin
        sys_clk = 1'b0;
        link_clk = 1'b0;
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    always #25 sys_clk = ~sys_clk;

    // device under test and its far side
    hts_ctrl #(.START_CYC_P(START_P), .TMP14_CYC_P(T14_N), .TMP11_CYC_P(T11_N),
        .HUM14_CYC_P(H14_N), .HUM11_CYC_P(H11_N), .HUM8_CYC_P(H8_N)) hts_ctrl_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk),
        .link_cfg_we(link_cfg_we), .link_cfg_wdata(link_cfg_wdata),
        .link_trig(link_trig), .link_trig_hum(link_trig_hum),
        .link_dev_ready(link_dev_ready), .scl_pin(scl_pin), .sda_pin(sda_pin),
        .scl_filt(scl_filt), .sda_filt(sda_filt), .supply_below_thr(supply_below_thr),
        .cfg_rdata(cfg_rdata), .supply_low_flag(supply_low_flag),
        .heater_enable(heater_enable), .heater_on(heater_on), .meas_active(meas_active),
        .dev_ready(dev_ready), .result_ready_n(result_ready_n));
    hts_link_master hts_link_master_inst (
        .link_clk(link_clk), .link_dev_ready(link_dev_ready), .link_cfg_we(link_cfg_we),
        .link_cfg_wdata(link_cfg_wdata), .link_trig(link_trig),
        .link_trig_hum(link_trig_hum));

    ////////////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // a wait that ran out of its bound
    task automatic give_up();
        chk(16'h0000, 16'h0001);
        wrap_up();
    endtask : give_up

    // reset values, start-up length and first supply sample
    task automatic t_reset();
        int n;
        n = 0;
        rst_b = 1'b0;
        supply_below_thr = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk(result_ready_n, 1'b1);
        chk({heater_enable, heater_on}, 2'b00);
        chk(cfg_rdata, 16'h0000);
        rst_b = 1'b1;
        while (dev_ready !== 1'b1 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 100)
            give_up();
        chk(n[15:0], START_P[15:0]);
        chk(meas_active, 1'b0);
        chk(supply_low_flag, 1'b1);
        exp_flag = 1'b1;
    endtask : t_reset

    // a one-period pulse is the longest spike to ignore; a long low must pass
    task automatic t_spike(input bit use_sda);
        if (use_sda)
            sda_pin = 1'b0;
        else
            scl_pin = 1'b0;
        @(negedge sys_clk);
        sda_pin = 1'b1;
        scl_pin = 1'b1;
        repeat (8)
        begin
            @(negedge sys_clk);
            chk({scl_filt, sda_filt}, 2'b11);
        end
        if (use_sda)
            sda_pin = 1'b0;
        else
            scl_pin = 1'b0;
        repeat (8) @(negedge sys_clk);
        chk({scl_filt, sda_filt}, use_sda ? 2'b10 : 2'b01);
        sda_pin = 1'b1;
        scl_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk({scl_filt, sda_filt}, 2'b11);
    endtask : t_spike

    // configure, trigger, time the conversion and watch heater and flag
    task automatic run_conv(input logic [15:0] cfg, input logic hum, input logic sup,
        input int exp_n);
        int n;
        n = 0;
        hts_link_master_inst.send_cfg(cfg);
        repeat (10) @(negedge sys_clk);
        chk(cfg_rdata, (cfg & 16'h3700) | {4'h0, exp_flag, 11'h000});
        chk(heater_enable, cfg[13]);
        supply_below_thr = sup;
        repeat (4) @(negedge sys_clk);
        hts_link_master_inst.send_trig(hum);
        while (meas_active !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 20) give_up();
        chk(result_ready_n, 1'b1);
        chk(supply_low_flag, sup);
        exp_flag = sup;
        supply_below_thr = ~sup;
        n = 0;
        while (meas_active === 1'b1 && n < 300)
        begin
            chk(heater_on, cfg[13]);
            n++;
            @(negedge sys_clk);
        end
        if (n == 300)
            give_up();
        chk(n[15:0], exp_n[15:0]);
        chk({result_ready_n, heater_on}, 2'b00);
        chk(supply_low_flag, sup);
    endtask : run_conv

    // bits outside the writable set, the flag bit among them, read back unchanged
    task automatic t_mask();
        hts_link_master_inst.send_cfg(16'hFFFF);
        repeat (10) @(negedge sys_clk);
        chk(cfg_rdata, 16'h3700 | {4'h0, exp_flag, 11'h000});
        chk(heater_enable, 1'b1);
    endtask : t_mask

    // faster triggering for heater warm-up: the second trigger aborts and restarts;
    // the count runs from the second request, so link-to-sys skew allows one extra
    task automatic t_retrig();
        int n;
        n = 0;
        hts_link_master_inst.send_cfg(16'h2000);
        supply_below_thr = 1'b0;
        repeat (10) @(negedge sys_clk);
        hts_link_master_inst.send_trig(1'b0);
        repeat (10) @(negedge sys_clk);
        chk({meas_active, heater_on, supply_low_flag}, 3'b110);
        hts_link_master_inst.send_trig(1'b0);
        while (meas_active === 1'b1 && n < 300)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 300)
            give_up();
        chk(16'(n >= T14_N + 3 && n <= T14_N + 4), 16'h0001);
        chk({result_ready_n, heater_on}, 2'b00);
        exp_flag = 1'b0;
    endtask : t_retrig

    // reset in mid-conversion drops a running heater and its enable at once
    task automatic t_reset_mid();
        hts_link_master_inst.send_trig(1'b0);
        repeat (10) @(negedge sys_clk);
        chk({heater_on, heater_enable}, 2'b11);
        t_reset();
    endtask : t_reset_mid

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        scl_pin = 1'b1;
        sda_pin = 1'b1;
        exp_flag = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        t_reset();
        t_spike(1'b0);
        t_spike(1'b1);
        run_conv(16'h0000, 1'b0, 1'b1, T14_N);
        run_conv(16'h0400, 1'b0, 1'b0, T11_N);
        t_mask();
        run_conv(16'h0000, 1'b1, 1'b1, H14_N);
        run_conv(16'h0100, 1'b1, 1'b0, H11_N);
        run_conv(16'h0200, 1'b1, 1'b1, H8_N);
        run_conv(16'h1600, 1'b1, 1'b0, T11_N + H8_N);
        run_conv(16'h2100, 1'b1, 1'b1, H11_N);
        run_conv(16'h0300, 1'b1, 1'b0, H14_N);
        t_retrig();
        t_reset_mid();
        run_conv(16'h0000, 1'b0, 1'b1, T14_N);
        wrap_up();
    end

endmodule : tb_top
